// *** core/fspa_pkg.sv ***
// constants and types shared by the self-programming controller and its core-side sequencer
package fspa_pkg;
	localparam int PTR_W = 16;
	localparam int PC_W = 13;
	localparam int PAGE_W = 7;
	localparam int WORD_W = 6;
	localparam int CTL_W = 8;
	localparam int CMD_W = 5;
	localparam int PAGE_WORDS = 64;
	// control register bit positions
	localparam int CTL_EN = 0;
	localparam int CTL_ERASE = 1;
	localparam int CTL_WRITE = 2;
	localparam int CTL_LOCK = 3;
	localparam int CTL_REEN = 4;
	localparam int CTL_BUSY = 6;
	localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
	// command codes held in the low five control bits
	localparam logic [CMD_W-1:0] CMD_LOAD = 5'h01;
	localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
	localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
	localparam logic [CMD_W-1:0] CMD_LOCK = 5'h09;
	localparam logic [CMD_W-1:0] CMD_REEN = 5'h11;
	// pointer field positions
	localparam int Z_BYTE = 0;
	localparam int Z_WORD_LO = 1;
	localparam int Z_WORD_HI = 6;
	localparam int Z_PAGE_LO = 7;
	localparam int Z_PAGE_HI = 13;
	// region limits
	localparam logic [PC_W-1:0] RWW_LAST = 13'h1BFF;
	localparam logic [PC_W-1:0] NO_READ_WHILE_WRITE_REGION_FIRST = 13'h1C00;
	localparam logic [PC_W-1:0] BOOT_START_11 = 13'h1F80;
	localparam logic [PC_W-1:0] BOOT_START_10 = 13'h1F00;
	localparam logic [PC_W-1:0] BOOT_START_01 = 13'h1E00;
	localparam logic [PC_W-1:0] BOOT_START_00 = 13'h1C00;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int PROG_MIN_NS = 3700000;
	localparam int PROG_MAX_NS = 4500000;
	localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	localparam logic [2:0] SPM_WINDOW = 3'h4;
	localparam logic [1:0] HOST_SETTLE = 2'h3;

	typedef logic [PC_W-1:0] fspa_addr_t;
	typedef logic [PAGE_W-1:0] fspa_page_t;

	function automatic fspa_addr_t fspa_boot_start(input logic [1:0] size);
		unique case (size)
			2'h3: fspa_boot_start = BOOT_START_11;
			2'h2: fspa_boot_start = BOOT_START_10;
			2'h1: fspa_boot_start = BOOT_START_01;
			2'h0: fspa_boot_start = BOOT_START_00;
		endcase
	endfunction
endpackage

// *** core/fspa_link_if.sv ***
// link between the core-side sequencer and the self-programming controller
`timescale 1ns/1ps
interface fspa_link_if;
	import fspa_pkg::*;
	logic ctl_wr;
	logic [CTL_W-1:0] ctl_wdata;
	logic [CTL_W-1:0] ctl_rdata;
	logic spm_exec;
	logic [PTR_W-1:0] z_ptr;
	logic [15:0] spm_data;
	logic core_sleep_pd;
	logic fetch_req;
	logic [PC_W-1:0] fetch_addr;
	logic fetch_grant;
	logic fetch_blocked;
	logic eeprom_write_in_progress;

	modport ctl_host (
		output ctl_wr, ctl_wdata, spm_exec, z_ptr, spm_data, core_sleep_pd,
		output fetch_req, fetch_addr,
		input ctl_rdata, fetch_grant, fetch_blocked, eeprom_write_in_progress
	);
	modport ctl_dev (
		input ctl_wr, ctl_wdata, spm_exec, z_ptr, spm_data, core_sleep_pd,
		input fetch_req, fetch_addr,
		output ctl_rdata, fetch_grant, fetch_blocked, eeprom_write_in_progress
	);
endinterface

// *** core/fspa_flash_ctrl.sv ***
// self-programming controller: timed command window, page operations, region blocking
`timescale 1ns/1ps
// Contract
// R1: reset mid-write lets the write finish
// R2: power-down sleep blocks control writes and commands
// R3: boot lock refuses writes into boot region
// R4: erase, write, lock last 3.7 to 4.5 ms
// R5: boot size code picks 128..1024 word region
// R6: boot region starts 1F80/1F00/1E00/1C00
// R7: rww is 0000-1BFF, no_read_while_write_region 1C00-1FFF
// R8: during erase/write only no_read_while_write_region may be read
// R9: 13-bit counter, 64-word pages
// R10: pointer bits sit one above counter bits
// R11: page number from pointer bits 13..7
// R12: word field from bits 6..1, zero on write
// R13: pointer 15..14 ignored, bit 0 zero; the lock command is taken with bit 0 set
// R14: software polls enable bit before commands
// R15: software waits eeprom idle before commands
// R16: erase, reenable, fill, write, reenable order
// R17: rww not read while busy flag set
// R18: command valid only within four cycles
// R19: busy flag cleared only by reenable command
// R20: enable bit held for whole operation
// R21: blocked rww fetches are withheld
module fspa_flash_ctrl #(
	parameter int unsigned PROG_CYCLES = fspa_pkg::PROG_MIN_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	fspa_link_if.ctl_dev link,
	input wire logic core_reset_req,
	input wire logic [1:0] boot_size,
	input wire logic boot_lock_spm,
	input wire logic eeprom_busy_in,
	output logic erase_start,
	output logic write_start,
	output logic lock_write,
	output logic [7:0] lock_data,
	output logic [fspa_pkg::PAGE_W-1:0] op_page,
	output logic buf_load,
	output logic [fspa_pkg::WORD_W-1:0] buf_word,
	output logic [15:0] buf_data,
	output logic buf_clear,
	output logic op_busy
);
	import fspa_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} fspa_ctl_state_t;

	localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
	localparam fspa_page_t NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = NO_READ_WHILE_WRITE_REGION_FIRST[PC_W-1:WORD_W];

	fspa_ctl_state_t state_r;
	logic [CMD_W-1:0] cmd_r;
	logic [2:0] win_r;
	logic [CNT_W-1:0] cnt_r;
	logic rww_busy_r;
	logic halt_all_r;
	logic was_write_r;
	logic op_busy_r;
	logic [CTL_W-1:0] ctl_rdata_r;
	logic fetch_grant_r;
	logic fetch_blocked_r;
	logic ee_busy_r;
	logic erase_start_r, write_start_r, lock_write_r, buf_load_r, buf_clear_r;
	logic [7:0] lock_data_r;
	logic [PAGE_W-1:0] op_page_r;
	logic [WORD_W-1:0] buf_word_r;
	logic [15:0] buf_data_r;

	// pointer decode: bits 15..14 never looked at
	wire [PAGE_W-1:0] z_page = link.z_ptr[Z_PAGE_HI:Z_PAGE_LO]; // [R10] [R11] [R13]
	wire [WORD_W-1:0] z_word = link.z_ptr[Z_WORD_HI:Z_WORD_LO]; // [R9] [R12]
	wire z_byte_ok = ~link.z_ptr[Z_BYTE]; // [R13]
	wire fspa_addr_t boot_start = fspa_boot_start(boot_size); // [R5] [R6]
	wire [PAGE_W-1:0] boot_first_page = boot_start[PC_W-1:WORD_W]; // [R5] [R6]
	wire boot_hit = boot_lock_spm && (z_page >= boot_first_page); // [R3]
	wire in_prog = (state_r == ST_PROG);
	wire op_done = in_prog && (cnt_r == '0);

	// sleeping core decodes nothing, and an eeprom write locks the control register out
	wire ctl_accept = link.ctl_wr && !link.core_sleep_pd && !ee_busy_r && !in_prog; // [R2]
	wire spm_take = link.spm_exec && !link.core_sleep_pd && (state_r == ST_ARMED); // [R2] [R18]
	wire load_go = spm_take && (cmd_r == CMD_LOAD) && z_byte_ok;
	wire erase_go = spm_take && (cmd_r == CMD_ERASE) && z_byte_ok && !boot_hit; // [R3]
	wire write_go = spm_take && (cmd_r == CMD_WRITE) && z_byte_ok && !boot_hit
		&& (z_word == '0); // [R3] [R12]
	wire lock_go = spm_take && (cmd_r == CMD_LOCK);
	wire reen_go = spm_take && (cmd_r == CMD_REEN) && z_byte_ok; // [R13]
	wire prog_go = erase_go || write_go || lock_go;
	wire page_in_no_read_while_write_region = (z_page >= NO_READ_WHILE_WRITE_REGION_FIRST_PAGE); // [R7]
	wire addr_in_rww = (link.fetch_addr <= RWW_LAST); // [R7]
	wire fetch_hold = halt_all_r || (rww_busy_r && addr_in_rww); // [R8] [R17]
	wire enable_shown = cmd_r[CTL_EN] || in_prog; // [R20]

	// core_reset_req leaves a running operation alone; only reset_n (supply) can stop it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			cmd_r <= '0;
			win_r <= '0;
			cnt_r <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (ctl_accept && !core_reset_req) begin
						state_r <= ST_ARMED;
						cmd_r <= link.ctl_wdata[CMD_W-1:0];
						win_r <= SPM_WINDOW - 3'h1; // [R18]
					end
				end
				ST_ARMED: begin
					if (core_reset_req) begin
						state_r <= ST_IDLE;
						cmd_r <= '0;
					end else if (prog_go) begin
						state_r <= ST_PROG;
						cnt_r <= PROG_LAST; // [R4]
					end else if (spm_take) begin
						state_r <= ST_IDLE;
						cmd_r <= '0;
					end else if (ctl_accept) begin
						cmd_r <= link.ctl_wdata[CMD_W-1:0];
						win_r <= SPM_WINDOW - 3'h1;
					end else if (win_r == 3'h0) begin
						state_r <= ST_IDLE; // [R18]
						cmd_r <= '0;
					end else begin
						win_r <= win_r - 3'h1;
					end
				end
				ST_PROG: begin
					if (op_done) begin
						state_r <= ST_IDLE; // [R1] [R20]
						cmd_r <= '0;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1); // [R4]
					end
				end
			endcase
		end
	end

	// busy flag: set by an erase or write, cleared only by a reenable command
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rww_busy_r <= 1'b0;
			halt_all_r <= 1'b0;
			was_write_r <= 1'b0;
			op_busy_r <= 1'b0;
		end else begin
			if (erase_go || write_go) begin
				rww_busy_r <= 1'b1; // [R8] [R19]
			end else if (reen_go) begin
				rww_busy_r <= 1'b0; // [R19]
			end
			if ((erase_go || write_go) && page_in_no_read_while_write_region) begin
				halt_all_r <= 1'b1;
			end else if (op_done) begin
				halt_all_r <= 1'b0;
			end
			// set by an erase, write or lock strobe even when core_reset_req keeps the state idle, cleared by op_done; the pin comes from a flop
			if (prog_go) begin
				was_write_r <= write_go;
				op_busy_r <= 1'b1; // [R20]
			end else if (op_done) begin
				op_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			erase_start_r <= 1'b0;
			write_start_r <= 1'b0;
			lock_write_r <= 1'b0;
			buf_load_r <= 1'b0;
			buf_clear_r <= 1'b0;
			lock_data_r <= '0;
			op_page_r <= '0;
			buf_word_r <= '0;
			buf_data_r <= '0;
		end else begin
			erase_start_r <= erase_go;
			write_start_r <= write_go;
			lock_write_r <= lock_go;
			buf_load_r <= load_go;
			// buffer empties after a page write, on reenable, and on system reset
			buf_clear_r <= reen_go || core_reset_req || (op_done && was_write_r);
			if (erase_go || write_go) begin
				op_page_r <= z_page; // [R11]
			end
			if (load_go) begin
				buf_word_r <= z_word; // [R12]
				buf_data_r <= link.spm_data;
			end
			if (lock_go) begin
				lock_data_r <= link.spm_data[7:0];
			end
		end
	end

	// withheld fetches get neither grant nor data; the core must retry
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_rdata_r <= CTL_RESET;
			fetch_grant_r <= 1'b0;
			fetch_blocked_r <= 1'b0;
			ee_busy_r <= 1'b0;
		end else begin
			ctl_rdata_r <= {1'b0, rww_busy_r, 1'b0, cmd_r[CMD_W-1:1], enable_shown}; // [R19] [R20]
			fetch_grant_r <= link.fetch_req && !fetch_hold; // [R21]
			fetch_blocked_r <= link.fetch_req && fetch_hold; // [R21]
			ee_busy_r <= eeprom_busy_in;
		end
	end

	assign link.ctl_rdata = ctl_rdata_r;
	assign link.fetch_grant = fetch_grant_r;
	assign link.fetch_blocked = fetch_blocked_r;
	assign link.eeprom_write_in_progress = ee_busy_r;
	assign erase_start = erase_start_r;
	assign write_start = write_start_r;
	assign lock_write = lock_write_r;
	assign lock_data = lock_data_r;
	assign op_page = op_page_r;
	assign buf_load = buf_load_r;
	assign buf_word = buf_word_r;
	assign buf_data = buf_data_r;
	assign buf_clear = buf_clear_r;
	assign op_busy = op_busy_r;
endmodule // fspa_flash_ctrl

// *** core/fspa_core_seq.sv ***
// core-side sequencer: runs a whole page update through the control register
`timescale 1ns/1ps
module fspa_core_seq (
	input wire logic mclk,
	input wire logic reset_n,
	fspa_link_if.ctl_host link,
	input wire logic start,
	input wire logic [fspa_pkg::PAGE_W-1:0] page,
	input wire logic [15:0] word_data,
	input wire logic sleep_req,
	input wire logic user_fetch_req,
	input wire logic [fspa_pkg::PC_W-1:0] user_fetch_addr,
	output logic [fspa_pkg::WORD_W-1:0] word_idx,
	output logic busy,
	output logic done,
	output logic fetch_ok,
	output logic fetch_held
);
	import fspa_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_POLL, H_EEWAIT, H_SETUP, H_EXEC, H_SETTLE}
		fspa_host_state_t;
	typedef enum logic [2:0] {S_ERASE, S_REEN1, S_FILL, S_WRITE, S_REEN2, S_CHECK}
		fspa_step_t;

	fspa_host_state_t state_r;
	fspa_step_t step_r;
	logic [PAGE_W-1:0] page_r;
	logic [WORD_W-1:0] idx_r;
	logic [1:0] settle_r;
	logic ctl_wr_r, spm_exec_r, done_r, sleep_r, freq_r, fok_r, fheld_r;
	logic busy_r;
	logic [CTL_W-1:0] wdata_r;
	logic [PTR_W-1:0] z_r;
	logic [15:0] data_r;
	logic [PC_W-1:0] faddr_r;

	wire [CMD_W-1:0] step_cmd = (step_r == S_ERASE) ? CMD_ERASE :
		(step_r == S_FILL) ? CMD_LOAD :
		(step_r == S_WRITE) ? CMD_WRITE : CMD_REEN; // [R16]
	// word field only used while filling, kept zero otherwise; bit 0 always zero
	wire [WORD_W-1:0] z_word = (step_r == S_FILL) ? idx_r : '0; // [R12] [R13]
	wire [PTR_W-1:0] z_nxt = {2'b00, page_r, z_word, 1'b0};
	wire enable_clear = ~link.ctl_rdata[CTL_EN];
	wire region_busy = link.ctl_rdata[CTL_BUSY];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= H_IDLE;
			step_r <= S_ERASE;
			page_r <= '0;
			idx_r <= '0;
			settle_r <= '0;
			ctl_wr_r <= 1'b0;
			spm_exec_r <= 1'b0;
			done_r <= 1'b0;
			wdata_r <= CTL_RESET;
			busy_r <= 1'b0;
			z_r <= '0;
			data_r <= '0;
		end else begin
			ctl_wr_r <= 1'b0;
			spm_exec_r <= 1'b0;
			done_r <= 1'b0;
			unique case (state_r)
				H_IDLE: begin
					if (start && !sleep_r) begin
						state_r <= H_POLL;
						step_r <= S_ERASE;
						page_r <= page;
						busy_r <= 1'b1;
						idx_r <= '0;
					end
				end
				H_POLL: begin
					if (enable_clear) begin // [R14]
						if (step_r == S_CHECK) begin
							// keep reenabling until the region reports ready
							state_r <= region_busy ? H_POLL : H_IDLE; // [R17]
							step_r <= region_busy ? S_REEN2 : S_CHECK;
							done_r <= !region_busy;
							busy_r <= region_busy;
						end else begin
							state_r <= H_EEWAIT;
						end
					end
				end
				H_EEWAIT: begin
					if (!link.eeprom_write_in_progress) begin // [R15]
						state_r <= H_SETUP;
						ctl_wr_r <= 1'b1;
						wdata_r <= {3'b000, step_cmd};
						z_r <= z_nxt;
						data_r <= word_data;
					end
				end
				H_SETUP: begin
					state_r <= H_EXEC;
					spm_exec_r <= 1'b1; // [R18]
				end
				H_EXEC: begin
					state_r <= H_SETTLE;
					settle_r <= HOST_SETTLE;
				end
				H_SETTLE: begin
					// status register lags the command by a cycle or two
					if (settle_r != 2'h0) begin
						settle_r <= settle_r - 2'h1;
					end else begin
						state_r <= H_POLL;
						unique case (step_r)
							S_ERASE: step_r <= S_REEN1;
							S_REEN1: step_r <= S_FILL;
							S_FILL: begin
								idx_r <= idx_r + WORD_W'(1);
								if (idx_r == WORD_W'(PAGE_WORDS - 1)) begin
									step_r <= S_WRITE;
								end
							end
							S_WRITE: step_r <= S_REEN2;
							S_REEN2: step_r <= S_CHECK;
							S_CHECK: step_r <= S_CHECK;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_r <= 1'b0;
			freq_r <= 1'b0;
			faddr_r <= '0;
			fok_r <= 1'b0;
			fheld_r <= 1'b0;
		end else begin
			sleep_r <= sleep_req && (state_r == H_IDLE); // [R2]
			freq_r <= user_fetch_req;
			faddr_r <= user_fetch_addr;
			fok_r <= link.fetch_grant;
			fheld_r <= link.fetch_blocked; // [R21]
		end
	end

	assign link.ctl_wr = ctl_wr_r;
	assign link.ctl_wdata = wdata_r;
	assign link.spm_exec = spm_exec_r;
	assign link.z_ptr = z_r;
	assign link.spm_data = data_r;
	assign link.core_sleep_pd = sleep_r;
	assign link.fetch_req = freq_r;
	assign link.fetch_addr = faddr_r;
	assign word_idx = idx_r;
	assign busy = busy_r;
	assign done = done_r;
	assign fetch_ok = fok_r;
	assign fetch_held = fheld_r;
endmodule // fspa_core_seq

// *** testbench/fspa_link_properties.sv ***
// link assertions for the sequencer-to-controller pair
`timescale 1ns/1ps
module fspa_link_properties (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ctl_wr,
	input wire logic [fspa_pkg::CTL_W-1:0] ctl_wdata,
	input wire logic [fspa_pkg::CTL_W-1:0] ctl_rdata,
	input wire logic spm_exec,
	input wire logic [fspa_pkg::PTR_W-1:0] z_ptr,
	input wire logic core_sleep_pd,
	input wire logic eeprom_write_in_progress,
	input wire logic fetch_req,
	input wire logic [fspa_pkg::PC_W-1:0] fetch_addr,
	input wire logic fetch_grant,
	input wire logic fetch_blocked
);
	import fspa_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_arm_write;
		ctl_wr && ctl_wdata[CTL_WRITE] && ctl_wdata[CTL_EN];
	endsequence
	// busy seen on two edges means the state flop was busy when the fetch was taken
	sequence s_rww_busy;
		fetch_req && fetch_addr <= RWW_LAST && ctl_rdata[CTL_BUSY] ##1 ctl_rdata[CTL_BUSY];
	endsequence
	sequence s_free;
		fetch_req && !ctl_rdata[CTL_BUSY] ##1 !ctl_rdata[CTL_BUSY];
	endsequence
	property p_exec_window;
		spm_exec |-> $past(ctl_wr, 1) || $past(ctl_wr, 2) || $past(ctl_wr, 3) || $past(ctl_wr, 4);
	endproperty
	a_exec_window: assert property (p_exec_window) else $error("store outside window");
	property p_z0;
		spm_exec |-> !z_ptr[Z_BYTE];
	endproperty
	a_z0: assert property (p_z0) else $error("pointer byte bit set");
	property p_write_word;
		s_arm_write |-> ##1 (spm_exec && z_ptr[Z_WORD_HI:Z_WORD_LO] == 6'h00);
	endproperty
	a_write_word: assert property (p_write_word) else $error("write with word field");
	property p_busy_clear;
		$fell(ctl_rdata[CTL_BUSY]) |-> $past(spm_exec, 2) || $past(spm_exec, 3) || $past(spm_exec, 4);
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy flag cleared alone");
	property p_rww_blocked;
		s_rww_busy |-> fetch_blocked && !fetch_grant;
	endproperty
	a_rww_blocked: assert property (p_rww_blocked) else $error("busy region fetched");
	property p_free_grant;
		s_free |-> fetch_grant && !fetch_blocked;
	endproperty
	a_free_grant: assert property (p_free_grant) else $error("idle fetch withheld");
	property p_fetch_answer;
		(fetch_grant || fetch_blocked) |-> $past(fetch_req) && !(fetch_grant && fetch_blocked);
	endproperty
	a_fetch_answer: assert property (p_fetch_answer) else $error("stray fetch answer");
	property p_arm;
		ctl_wr && ctl_wdata[CTL_EN] && !ctl_rdata[CTL_EN] && !core_sleep_pd
			&& !eeprom_write_in_progress |-> ##2 ctl_rdata[CTL_EN];
	endproperty
	a_arm: assert property (p_arm) else $error("enable not armed");
	property p_enable_hold;
		$rose(ctl_rdata[CTL_BUSY]) |-> ctl_rdata[CTL_EN] [*8];
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("enable dropped early");
endmodule // fspa_link_properties

// *** testbench/tb.sv ***
// bench: sequencer pair plus a directly driven controller for refusals
`timescale 1ns/1ps
module tb;
	import fspa_pkg::*;
	localparam int PC = 20;
	logic mclk = 0;
	logic reset_n = 0;
	always #2.5 mclk = ~mclk;
	int fails = 0;
	int samples_checked = 0;
	logic [31:0] rng = 32'h68E6AA2E;
	fspa_link_if l1 ();
	fspa_link_if l2 ();
	logic start = 0, coll = 0, crr2 = 0, lck = 0, ee1 = 0, ee2 = 0;
	logic [1:0] bsz = 2'h3;
	logic [6:0] seq_page = 7'h00;
	logic [12:0] fa = 13'h0000;
	logic [4:0] pv1, pv2, seen;
	logic [5:0] word_idx, buf_word1, buf_word2;
	logic [15:0] buf_data1, buf_data2;
	logic [6:0] op_page1, op_page2;
	logic [7:0] lock_data2;
	logic busy1, busy2, done, sbusy, fok, fheld;
	int run = 0, last_len = 0, n_load = 0, n_er = 0, n_wr = 0, n_ok = 0, n_held = 0;
	function automatic logic [4:0] pick_cmd(input int k);
		case (k % 6)
			0: pick_cmd = CMD_REEN;
			1: pick_cmd = CMD_LOCK;
			2: pick_cmd = CMD_WRITE;
			3: pick_cmd = CMD_ERASE;
			4: pick_cmd = CMD_LOAD;
			default: pick_cmd = 5'h07;
		endcase
	endfunction
	function automatic logic [15:0] wd(input logic [5:0] w);
		wd = {w, ~w, 4'hA};
	endfunction
	function automatic logic [31:0] nx(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		nx = t ^ (t << 5);
	endfunction
	// pulse order: erase, write, lock, load, clear
	function automatic logic [4:0] exp_go(input logic [4:0] c, input logic [15:0] z,
		input int gap, input logic slp);
		logic [13:0] bst;
		logic inboot;
		bst = 14'h2000 - (14'h0080 << (3 - bsz));
		inboot = lck && {1'b0, z[13:7], 6'h00} >= bst;
		exp_go = 5'h00;
		if (slp || gap > 4)
			return exp_go;
		case (c)
			CMD_LOAD: exp_go = z[0] ? 5'h00 : 5'h08;
			CMD_ERASE: exp_go = (z[0] || inboot) ? 5'h00 : 5'h01;
			CMD_WRITE: exp_go = (z[0] || inboot || z[6:1] != 6'h00) ? 5'h00 : 5'h02;
			CMD_LOCK: exp_go = 5'h04;
			CMD_REEN: exp_go = z[0] ? 5'h00 : 5'h10;
			default: exp_go = 5'h00;
		endcase
	endfunction
	assign pv1[2] = 1'b0;
	fspa_core_seq fspa_core_seq_i (.mclk(mclk), .reset_n(reset_n), .link(l1), .start(start),
		.page(seq_page), .word_data(wd(word_idx)), .sleep_req(1'b0), .user_fetch_req(fa[0]),
		.user_fetch_addr(fa), .word_idx(word_idx), .busy(sbusy), .done(done), .fetch_ok(fok),
		.fetch_held(fheld));
	fspa_flash_ctrl #(.PROG_CYCLES(PC)) fspa_flash_ctrl_i (.mclk(mclk), .reset_n(reset_n),
		.link(l1), .core_reset_req(1'b0), .boot_size(bsz), .boot_lock_spm(1'b0),
		.eeprom_busy_in(ee1), .erase_start(pv1[0]), .write_start(pv1[1]), .lock_write(),
		.lock_data(), .op_page(op_page1), .buf_load(pv1[3]), .buf_word(buf_word1),
		.buf_data(buf_data1), .buf_clear(pv1[4]), .op_busy(busy1));
	fspa_flash_ctrl #(.PROG_CYCLES(PC)) fspa_flash_ctrl_i2 (.mclk(mclk), .reset_n(reset_n),
		.link(l2), .core_reset_req(crr2), .boot_size(bsz), .boot_lock_spm(lck),
		.eeprom_busy_in(ee2), .erase_start(pv2[0]), .write_start(pv2[1]),
		.lock_write(pv2[2]), .lock_data(lock_data2), .op_page(op_page2), .buf_load(pv2[3]),
		.buf_word(buf_word2), .buf_data(buf_data2), .buf_clear(pv2[4]), .op_busy(busy2));
	fspa_link_properties fspa_link_properties_i (.mclk(mclk), .reset_n(reset_n),
		.ctl_wr(l1.ctl_wr), .ctl_wdata(l1.ctl_wdata), .ctl_rdata(l1.ctl_rdata),
		.spm_exec(l1.spm_exec), .z_ptr(l1.z_ptr), .core_sleep_pd(l1.core_sleep_pd),
		.eeprom_write_in_progress(l1.eeprom_write_in_progress), .fetch_req(l1.fetch_req),
		.fetch_addr(l1.fetch_addr), .fetch_grant(l1.fetch_grant),
		.fetch_blocked(l1.fetch_blocked));
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(negedge mclk) begin
		fa <= fa + 13'h0155;
		// eeprom writes start only while a command is armed or running, as software would
		ee1 <= (fa[12:9] == 4'h0) && (ee1 || l1.ctl_rdata[CTL_EN]);
	end
	always @(posedge mclk) begin
		seen <= coll ? (seen | pv2) : 5'h00;
		run <= busy2 ? run + 1 : 0;
		if (!busy2 && run != 0)
			last_len <= run;
		n_er <= n_er + pv1[0];
		n_wr <= n_wr + pv1[1];
		n_load <= n_load + pv1[3];
		n_ok <= n_ok + fok;
		n_held <= n_held + fheld;
		if (pv1[3] === 1'b1)
			check("load data", buf_data1, wd(buf_word1));
	end
	task automatic cmd(input logic [4:0] c, input logic [15:0] z, input logic [15:0] d,
		input int gap, input logic slp, input logic mid_rst);
		logic [4:0] e;
		int n;
		n = 0;
		while ((l2.ctl_rdata[CTL_EN] !== 1'b0 || l2.eeprom_write_in_progress !== 1'b0)
			&& n < 300) begin
			@(negedge mclk);
			n++;
		end
		check("ready wait", n < 300, 1);
		e = exp_go(c, z, gap, slp);
		{l2.core_sleep_pd, l2.ctl_wr, l2.ctl_wdata, l2.z_ptr, l2.spm_data} = {slp, 1'b1,
			3'h0, c, z, d};
		@(negedge mclk);
		l2.ctl_wr = 0;
		repeat (gap - 1) @(negedge mclk);
		l2.spm_exec = 1;
		coll = 1;
		@(negedge mclk);
		l2.spm_exec = 0;
		repeat (3) @(negedge mclk);
		coll = 0;
		check("pulses", seen, e);
		if (e[1:0] != 2'h0)
			check("page", op_page2, z[13:7]);
		if (e[3])
			check("word", {buf_word2, buf_data2}, {z[6:1], d});
		if (e[2])
			check("lock", lock_data2, d[7:0]);
		l2.core_sleep_pd = 0;
		crr2 = mid_rst;
		@(negedge mclk);
		crr2 = 0;
		while (busy2 !== 1'b0 && n < 600) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		check("op end wait", n < 600, 1);
		if (e[2:0] != 3'h0)
			check("op length", last_len, PC);
	endtask
	task automatic fetch2(input logic [12:0] a, input logic [1:0] exp);
		l2.fetch_req = 1;
		l2.fetch_addr = a;
		@(negedge mclk);
		check("fetch", {l2.fetch_grant, l2.fetch_blocked}, exp);
		l2.fetch_req = 0;
		@(negedge mclk);
	endtask
	initial begin
		#200000;
		fails++;
		give_verdict();
	end
	initial begin
		logic [7:0] pg;
		int n;
		{l2.ctl_wr, l2.ctl_wdata, l2.spm_exec, l2.z_ptr, l2.spm_data} = '0;
		{l2.core_sleep_pd, l2.fetch_req, l2.fetch_addr} = '0;
		repeat (4) @(negedge mclk);
		reset_n = 1;
		seq_page = rng[6:0] % 7'd112;
		start = 1;
		@(negedge mclk);
		start = 0;
		check("seq busy", sbusy, 1'b1);
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		check("seq finished", n < 20000, 1);
		repeat (2) @(negedge mclk);
		check("seq loads", n_load, 64);
		check("seq erases", n_er, 1);
		check("seq writes", n_wr, 1);
		check("seq page", op_page1, seq_page);
		check("seq idle", sbusy, 1'b0);
		check("fetch held seen", n_held != 0, 1);
		check("fetch ok seen", n_ok != 0, 1);
		lck = 1;
		for (int b = 0; b < 4; b++) begin
			bsz = b[1:0];
			pg = 8'h80 - (8'h02 << (3 - b));
			cmd(CMD_ERASE, {2'h0, pg[6:0], 7'h00}, 16'h0000, 1, 0, 0);
			pg = pg - 8'h01;
			cmd(CMD_ERASE, {2'h0, pg[6:0], 7'h00}, 16'h0000, 2, 0, 0);
		end
		fetch2(RWW_LAST, 2'h1);
		fetch2(NO_READ_WHILE_WRITE_REGION_FIRST, 2'h2);
		cmd(CMD_REEN, 16'h0000, 16'h0000, 3, 0, 0);
		fetch2(RWW_LAST, 2'h2);
		cmd(CMD_LOAD, 16'hC07E, 16'h1234, 4, 0, 0);
		cmd(CMD_LOAD, 16'h007E, 16'h1234, 5, 0, 0);
		cmd(CMD_LOAD, 16'h0003, 16'h5678, 1, 0, 0);
		cmd(CMD_ERASE, 16'h0280, 16'h0000, 1, 1, 0);
		cmd(CMD_WRITE, 16'h0282, 16'h0000, 1, 0, 0);
		cmd(CMD_WRITE, 16'h0280, 16'h0000, 1, 0, 1);
		cmd(CMD_LOCK, 16'h0001, 16'h00C3, 2, 0, 0);
		for (int i = 0; i < 40; i++) begin
			rng = nx(rng);
			{lck, bsz} = rng[29:27];
			ee2 = rng[23];
			repeat (2) @(negedge mclk);
			ee2 = 0;
			cmd(pick_cmd(i),
				{rng[15:7], rng[20] ? rng[6:1] : 6'h00, rng[21] & rng[22]}, rng[31:16],
				1 + rng[26:24] % 5, rng[31:29] == 3'h0, 0);
		end
		give_verdict();
	end
endmodule // tb
